/* File: verilog/vmon_seq_pkg.sv */
// constants, types and device register map for the voltage monitor reset arming sequencer
// What this block does
// - write the four-bit detection level field first
// - filtered variant: set circuit enable right after the level
// - wait the detector settle time after circuit enable
// - with filter in use, program the two-bit sampling clock select
// - with filter in use, clear filter disable after the clock select
// - with filter in use, wait 2n+3 low-speed oscillator cycles
// - then set reset select to 1 and the chosen negation type
// - filtered variant: clear the detection flag before reset enable
// - after the flag clear, set interrupt/reset enable to 1
// - last step of both variants sets comparison output enable
// - plain variant: level, reset select and negation, then reset enable
// - plain variant: circuit enable after reset enable, settle, then compare enable
package vmon_seq_pkg;

    // apb register offsets of the controller
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] STATUS_OFS   = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_EN_OFS   = 8'h0C;
    localparam logic [7:0] IRQ_CLR_OFS  = 8'h10;

    // control register fields
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_PLAIN_BIT  = 1;
    localparam int CTRL_FILTER_BIT = 2;
    localparam int CTRL_NEG_BIT    = 3;
    localparam int CTRL_LVL_LSB    = 4;
    localparam int CTRL_FSAMP_LSB  = 8;

    // status and interrupt bits
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_DONE_BIT   = 1;
    localparam int STAT_RST_BIT    = 2;
    localparam int STAT_DET_BIT    = 3;
    localparam int IRQ_DONE_BIT    = 0;
    localparam int IRQ_RST_BIT     = 1;
    localparam int IRQ_DET_BIT     = 2;
    localparam int IRQ_W           = 3;

    // device register addresses on the device write port
    localparam logic [7:0] LEVEL_SELECT_REG    = 8'h00;
    localparam logic [7:0] COMPARATOR_CTRL_REG = 8'h01;
    localparam logic [7:0] MON1_CTRL0_REG      = 8'h02;
    localparam logic [7:0] MON1_STATUS_REG     = 8'h03;

    // device field masks
    localparam logic [7:0] MON1_LEVEL_FIELD    = 8'h0F;
    localparam logic [7:0] MON1_CIRCUIT_EN     = 8'h01;
    localparam logic [7:0] MON1_INT_RESET_EN   = 8'h01;
    localparam logic [7:0] MON1_FILTER_DISABLE = 8'h02;
    localparam logic [7:0] MON1_CMP_OUT_EN     = 8'h04;
    localparam logic [7:0] MON1_FILTER_CLK_SEL = 8'h30;
    localparam logic [7:0] MON1_NEGATION_TYPE  = 8'h40;
    localparam logic [7:0] MON1_RESET_SELECT   = 8'h80;
    localparam logic [7:0] MON1_DETECT_FLAG    = 8'h01;
    localparam int         FSAMP_LSB           = 4;
    localparam int         NEG_LSB             = 6;

    // timing
    localparam int CLK_NS         = 100;
    localparam int FILT_MUL       = 2;
    localparam int FILT_ADD       = 3;
    localparam int CNT_W          = 24;

    typedef enum {
        S_IDLE, S_LEVEL, S_CIRC, S_SETTLE, S_FSAMP, S_FDIS, S_FWAIT,
        S_RSEL, S_DETCLR, S_RIE, S_CIRC2, S_SETTLE2, S_CMPE
    } step_type;

    // one masked write to the device: bits under mask take data
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] mask;
        logic [7:0] data;
    } dev_cmd_type;

    typedef struct packed {
        logic       plain;
        logic       use_filter;
        logic       negation;
        logic [3:0] level;
        logic [1:0] fsamp;
    } cfg_type;

endpackage

/* File: verilog/vmon_seq.sv */
// apb-programmed controller that arms voltage monitor 1 for reset through device writes
`timescale 1ns/100ps
module vmon_seq #(
    parameter int SETTLE_NS = 1000,
    parameter int LOW_SPEED_OSC_NS   = 4000
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic                           pready,
    output logic [31:0]                    prdata,
    output logic                           pslverr,
    output vmon_seq_pkg::dev_cmd_type      dev_cmd,
    input  wire logic                      dev_ack,
    input  wire logic                      mon1_reset_pin,
    input  wire logic                      mon1_detect_pin,
    output logic                           irq
);
    import vmon_seq_pkg::*;

    localparam int SETTLE_CYC_RAW = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_CYC     = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
    localparam int LOW_SPEED_OSC_CYC_RAW   = (LOW_SPEED_OSC_NS + CLK_NS - 1) / CLK_NS;
    localparam int LOW_SPEED_OSC_CYC       = (LOW_SPEED_OSC_CYC_RAW < 1) ? 1 : LOW_SPEED_OSC_CYC_RAW;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // step that follows a finished one; plain and filtered orders differ
    function automatic step_type next_step(input step_type s, input cfg_type c);
        step_type n;
        n = S_IDLE;
        case (s)
            S_LEVEL:   n = c.plain ? S_RSEL : S_CIRC;
            S_CIRC:    n = S_SETTLE;
            S_SETTLE:  n = c.use_filter ? S_FSAMP : S_RSEL;
            S_FSAMP:   n = S_FDIS;
            S_FDIS:    n = S_FWAIT;
            S_FWAIT:   n = S_RSEL;
            S_RSEL:    n = c.plain ? S_RIE : S_DETCLR;
            S_DETCLR:  n = S_RIE;
            S_RIE:     n = c.plain ? S_CIRC2 : S_CMPE;
            S_CIRC2:   n = S_SETTLE2;
            S_SETTLE2: n = S_CMPE;
            default:   n = S_IDLE;
        endcase
        return n;
    endfunction

    // device write issued in a step; waits and idle issue none
    function automatic dev_cmd_type step_cmd(input step_type s, input cfg_type c);
        dev_cmd_type d;
        d = '0;
        d.valid = 1'b1;
        case (s)
            S_LEVEL: begin
                d.addr = LEVEL_SELECT_REG;
                d.mask = MON1_LEVEL_FIELD;
                d.data = {4'h0, c.level};
            end
            S_CIRC, S_CIRC2: begin
                d.addr = COMPARATOR_CTRL_REG;
                d.mask = MON1_CIRCUIT_EN;
                d.data = MON1_CIRCUIT_EN;
            end
            S_FSAMP: begin
                d.addr = MON1_CTRL0_REG;
                d.mask = MON1_FILTER_CLK_SEL;
                d.data = 8'(c.fsamp) << FSAMP_LSB;
            end
            S_FDIS: begin
                d.addr = MON1_CTRL0_REG;
                d.mask = MON1_FILTER_DISABLE;
                d.data = 8'h00;
            end
            S_RSEL: begin
                d.addr = MON1_CTRL0_REG;
                d.mask = MON1_RESET_SELECT | MON1_NEGATION_TYPE;
                d.data = MON1_RESET_SELECT | (8'(c.negation) << NEG_LSB);
            end
            S_DETCLR: begin
                d.addr = MON1_STATUS_REG;
                d.mask = MON1_DETECT_FLAG;
                d.data = 8'h00;
            end
            S_RIE: begin
                d.addr = MON1_CTRL0_REG;
                d.mask = MON1_INT_RESET_EN;
                d.data = MON1_INT_RESET_EN;
            end
            S_CMPE: begin
                d.addr = MON1_CTRL0_REG;
                d.mask = MON1_CMP_OUT_EN;
                d.data = MON1_CMP_OUT_EN;
            end
            default: d = '0;
        endcase
        return d;
    endfunction

    // wait length in pclk cycles for the step that is about to start
    function automatic logic [CNT_W-1:0] wait_len(input step_type s, input cfg_type c);
        logic [CNT_W-1:0] n;
        // shift amount widened: select 3 plus one must reach 4, not wrap to 0
        n = CNT_W'(FILT_MUL) << (3'(c.fsamp) + 3'd1);                 // 2n, n = 2..16
        if (s == S_FWAIT)
            wait_len = CNT_W'((n + CNT_W'(FILT_ADD)) * CNT_W'(LOW_SPEED_OSC_CYC));
        else
            wait_len = CNT_W'(SETTLE_CYC);
    endfunction

    function automatic logic is_wait(input step_type s);
        return (s == S_SETTLE) || (s == S_SETTLE2) || (s == S_FWAIT);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // device status pins: two flops before any use

    logic [1:0] rst_sync;
    logic [1:0] det_sync;
    logic [1:0] next_rst_sync;
    logic [1:0] next_det_sync;
    logic       rst_seen;
    logic       det_seen;

    always_comb begin
        next_rst_sync = {rst_sync[0], mon1_reset_pin};
        next_det_sync = {det_sync[0], mon1_detect_pin};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_sync <= 2'b00;
            det_sync <= 2'b00;
            rst_seen <= 1'b0;
            det_seen <= 1'b0;
        end else begin
            rst_sync <= next_rst_sync;
            det_sync <= next_det_sync;
            rst_seen <= rst_sync[1];
            det_seen <= det_sync[1];
        end
    end

    // edges of the device's response once armed
    logic rst_rise;
    logic det_rise;
    assign rst_rise = rst_sync[1] & ~rst_seen;
    assign det_rise = det_sync[1] & ~det_seen;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    step_type         step;
    step_type         next_step_q;
    cfg_type          cfg;
    cfg_type          next_cfg;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    dev_cmd_type      next_dev_cmd;
    logic             done;
    logic             next_done;
    logic             done_pulse;
    logic             wr_ctrl;
    logic             start_req;

    assign wr_ctrl   = psel & penable & pwrite & (paddr == CTRL_OFS);
    assign start_req = wr_ctrl & pwdata[CTRL_START_BIT];

    // a step moves on when its device write is acked or its wait expires;
    // start while busy is ignored so config cannot change mid-sequence
    always_comb begin
        next_step_q  = step;
        next_cfg     = cfg;
        next_cnt     = cnt;
        next_done    = done;
        done_pulse   = 1'b0;
        next_dev_cmd = dev_cmd;
        if (step == S_IDLE) begin
            if (start_req) begin
                next_cfg.plain      = pwdata[CTRL_PLAIN_BIT];
                next_cfg.use_filter = pwdata[CTRL_FILTER_BIT] & ~pwdata[CTRL_PLAIN_BIT];
                next_cfg.negation   = pwdata[CTRL_NEG_BIT];
                next_cfg.level      = pwdata[CTRL_LVL_LSB +: 4];
                next_cfg.fsamp      = pwdata[CTRL_FSAMP_LSB +: 2];
                next_done           = 1'b0;
                next_step_q         = S_LEVEL;
                next_dev_cmd        = step_cmd(S_LEVEL, next_cfg);
            end
        end else if (is_wait(step)) begin
            if (cnt <= CNT_W'(1)) begin
                next_step_q  = next_step(step, cfg);
                next_dev_cmd = step_cmd(next_step_q, cfg);
            end else begin
                next_cnt = cnt - CNT_W'(1);
            end
        end else if (dev_ack) begin
            next_step_q = next_step(step, cfg);
            if (step == S_CMPE) begin
                next_done  = 1'b1;
                done_pulse = 1'b1;
            end
            if (is_wait(next_step_q)) begin
                next_cnt     = wait_len(next_step_q, cfg);
                next_dev_cmd = '0;
            end else begin
                next_dev_cmd = step_cmd(next_step_q, cfg);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step    <= S_IDLE;
            cfg     <= '0;
            cnt     <= '0;
            done    <= 1'b0;
            dev_cmd <= '0;
        end else begin
            step    <= next_step_q;
            cfg     <= next_cfg;
            cnt     <= next_cnt;
            done    <= next_done;
            dev_cmd <= next_dev_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt registers and apb slave

    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] next_irq_en;
    logic [IRQ_W-1:0] irq_set;
    logic [31:0]      next_prdata;
    logic             next_pslverr;
    logic             mapped;
    logic             setup;
    logic             wr_access;

    assign setup     = psel & ~penable;
    assign wr_access = psel & penable & pwrite;
    assign pready    = psel & penable;                                 // zero wait states
    assign irq       = |(irq_stat & irq_en);

    always_comb begin
        irq_set                = '0;
        irq_set[IRQ_DONE_BIT]  = done_pulse;
        irq_set[IRQ_RST_BIT]   = rst_rise;
        irq_set[IRQ_DET_BIT]   = det_rise;
    end

    // a new event in the clear cycle survives: set is or-ed after the clear
    always_comb begin
        next_irq_stat = irq_stat;
        next_irq_en   = irq_en;
        if (wr_access && paddr == IRQ_CLR_OFS)
            next_irq_stat = irq_stat & ~pwdata[IRQ_W-1:0];
        next_irq_stat = next_irq_stat | irq_set;
        if (wr_access && paddr == IRQ_EN_OFS)
            next_irq_en = pwdata[IRQ_W-1:0];
    end

    // read data and error are captured in the setup cycle, held in access
    always_comb begin
        mapped       = 1'b1;
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (setup) begin
            next_prdata = 32'h0000_0000;
            case (paddr)
                CTRL_OFS: begin
                    next_prdata[CTRL_PLAIN_BIT]         = cfg.plain;
                    next_prdata[CTRL_FILTER_BIT]        = cfg.use_filter;
                    next_prdata[CTRL_NEG_BIT]           = cfg.negation;
                    next_prdata[CTRL_LVL_LSB +: 4]      = cfg.level;
                    next_prdata[CTRL_FSAMP_LSB +: 2]    = cfg.fsamp;
                end
                STATUS_OFS: begin
                    next_prdata[STAT_BUSY_BIT] = (step != S_IDLE);
                    next_prdata[STAT_DONE_BIT] = done;
                    next_prdata[STAT_RST_BIT]  = rst_sync[1];
                    next_prdata[STAT_DET_BIT]  = det_sync[1];
                end
                IRQ_STAT_OFS: next_prdata[IRQ_W-1:0] = irq_stat;
                IRQ_EN_OFS:   next_prdata[IRQ_W-1:0] = irq_en;
                IRQ_CLR_OFS:  next_prdata = 32'h0000_0000;
                default:      mapped = 1'b0;
            endcase
            next_pslverr = ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
            irq_en   <= '0;
            prdata   <= 32'h0000_0000;
            pslverr  <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_en   <= next_irq_en;
            prdata   <= next_prdata;
            pslverr  <= next_pslverr;
        end
    end

endmodule

/* File: dv/vmon_seq_properties.sv */
// concurrent checks on the device write order and waits of the arming controller
`timescale 1ns/100ps
module vmon_seq_properties #(
    parameter int SETTLE_NS = 1000,
    parameter int LOW_SPEED_OSC_NS   = 4000
) (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pready,
    input wire logic [7:0]                paddr,
    input wire logic                      pslverr,
    input wire vmon_seq_pkg::dev_cmd_type dev_cmd,
    input wire logic                      dev_ack
);
    import vmon_seq_pkg::*;
    localparam int SC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int LC = (LOW_SPEED_OSC_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_CYC = (SC < 1) ? 1 : SC;
    localparam int LOW_SPEED_OSC_CYC = (LC < 1) ? 1 : LC;
    localparam logic [15:0] LVL = 16'h000F, CIRC = 16'h0101, FS = 16'h0230, FD = 16'h0202;
    localparam logic [15:0] RS = 16'h02C0, DC = 16'h0301, RIE = 16'h0201, CMP = 16'h0204;
    logic [15:0] last, next_last;
    logic [1:0]  sel, next_sel;
    int          gap, next_gap;
    logic        taken_q, valid_q;
    wire  [15:0] kind  = {dev_cmd.addr, dev_cmd.mask};
    wire         taken = dev_cmd.valid && dev_ack;
    wire         fresh = dev_cmd.valid && (taken_q || !valid_q);
    ////////////////////////////////////////////////////////////////////////////////
    // remember the last accepted write and count idle cycles since it
    always_comb begin
        next_last = last;
        next_sel = sel;
        next_gap = gap;
        if (taken) begin
            next_last = kind;
            next_gap = 0;
            if (kind == FS) next_sel = dev_cmd.data[5:4];
        end else if (!dev_cmd.valid) begin
            next_gap = gap + 1;
        end
    end
    // gap is not saturated but never wraps in practice: waits are far below int range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 16'h0000;
            sel <= 2'h0;
            gap <= 0;
            taken_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            last <= next_last;
            sel <= next_sel;
            gap <= next_gap;
            taken_q <= taken;
            valid_q <= dev_cmd.valid;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_cmpe_taken;
        taken && kind == CMP;
    endsequence
    a_pready_no_wait: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_cmd_held: assert property (dev_cmd.valid && !dev_ack |=> $stable(dev_cmd))
        else $error("device write changed before ack");
    a_level_first: assert property (fresh && (last == CMP || last == 16'h0) |-> kind == LVL)
        else $error("sequence did not open with level write");
    a_circ_order: assert property (fresh && kind == CIRC |-> last == LVL || last == RIE)
        else $error("circuit enable out of order");
    a_settle_wait: assert property (fresh && last == CIRC |-> gap >= SETTLE_CYC)
        else $error("settle wait too short");
    a_fsamp_after: assert property (fresh && kind == FS |-> last == CIRC)
        else $error("clock select out of order");
    a_fdis_after: assert property (fresh && kind == FD |-> last == FS)
        else $error("filter enable out of order");
    a_filter_wait: assert property (fresh && last == FD |-> gap >= (2 * (2 << sel) + 3) * LOW_SPEED_OSC_CYC)
        else $error("filter wait too short");
    a_reset_sel: assert property (dev_cmd.valid && kind == RS |-> dev_cmd.data[7])
        else $error("reset select not set");
    a_rie_order: assert property (fresh && kind == RIE |-> last == DC || last == RS)
        else $error("reset enable out of order");
    a_cmpe_last: assert property (s_cmpe_taken |=> !dev_cmd.valid [*2])
        else $error("write after compare enable");
    a_unmapped_err: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
        else $error("unmapped access not flagged");
endmodule
bind vmon_seq vmon_seq_properties #(.SETTLE_NS(SETTLE_NS), .LOW_SPEED_OSC_NS(LOW_SPEED_OSC_NS)) props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .paddr(paddr), .pslverr(pslverr), .dev_cmd(dev_cmd), .dev_ack(dev_ack));

/* File: dv/vmon_dev_model.sv */
// behavioural voltage monitor device: masked register writes, filter and reset output
`timescale 1ns/100ps
module vmon_dev_model (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire vmon_seq_pkg::dev_cmd_type dev_cmd,
    input  wire logic                      slow,
    input  wire logic                      supply_low,
    output logic                           dev_ack,
    output logic                           mon1_reset_pin,
    output logic                           mon1_detect_pin
);
    import vmon_seq_pkg::*;
    logic [7:0]  regs [0:3];
    logic [23:0] log_cmd [$];
    int          log_cyc [$];
    int          cyc, hold, div;
    logic        filt;
    wire         armed = regs[1][0] && regs[2][2];
    ////////////////////////////////////////////////////////////////////////////////
    // ack after a short or long hold; the oscillator is modelled at one pclk per cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regs <= '{8'h00, 8'h00, 8'h02, 8'h00};
            dev_ack <= 1'b0;
            {cyc, hold, div, filt} <= '0;
        end else begin
            cyc <= cyc + 1;
            dev_ack <= 1'b0;
            if (dev_cmd.valid && !dev_ack) begin
                hold <= (hold >= (slow ? 3 : 0)) ? 0 : hold + 1;
                dev_ack <= hold >= (slow ? 3 : 0);
            end
            if (dev_ack && dev_cmd.valid) begin
                regs[dev_cmd.addr[1:0]] <= (regs[dev_cmd.addr[1:0]] & ~dev_cmd.mask)
                                           | (dev_cmd.data & dev_cmd.mask);
                log_cmd.push_back({dev_cmd.addr, dev_cmd.mask, dev_cmd.data});
                log_cyc.push_back(cyc);
            end
            // filter samples once per n oscillator cycles, n = 2 << select
            div <= (div >= (2 << regs[2][5:4]) - 1) ? 0 : div + 1;
            if (regs[2][1] || div == 0) filt <= supply_low;
            if (armed && filt) regs[3][0] <= 1'b1;
        end
    end
    // reset needs reset select and reset enable as well as the comparator
    assign mon1_reset_pin = armed && filt && regs[2][7] && regs[2][0];
    assign mon1_detect_pin = regs[3][0];
endmodule

/* File: dv/vmon_seq_bench.sv */
// self-checking bench for the voltage monitor arming controller
`timescale 1ns/100ps
module vmon_seq_bench;
    import vmon_seq_pkg::*;
    localparam int S = 2;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        slow = 0, supply_low = 0, er;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic        pready, pslverr, dev_ack, rst_pin, det_pin, irq;
    logic [31:0] prdata;
    dev_cmd_type dev_cmd;
    logic [23:0] exp_q [$];
    int          gap_q [$];
    int          bad_count = 0, num_checks = 0, cyc = 0;
    vmon_seq #(.SETTLE_NS(200), .LOW_SPEED_OSC_NS(100)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .dev_cmd(dev_cmd),
        .dev_ack(dev_ack), .mon1_reset_pin(rst_pin), .mon1_detect_pin(det_pin), .irq(irq));
    vmon_dev_model dev (.pclk(pclk), .presetn(presetn), .dev_cmd(dev_cmd), .slow(slow),
        .supply_low(supply_low), .dev_ack(dev_ack), .mon1_reset_pin(rst_pin),
        .mon1_detect_pin(det_pin));
    always #50 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    // cut a hang short; the whole run needs well under this many cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s: seen %h expected %h", $time, m, seen, exp);
        end
    endtask
    // one apb transfer; read data and error are taken at the pready edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic add(input logic [23:0] c, input int g);
        exp_q.push_back(c);
        gap_q.push_back(g);
    endtask
    // start a run (a second start while busy must be ignored) and judge the writes
    task automatic run(input logic pl, fl, ng, input logic [3:0] lv, input logic [1:0] sl);
        int w;
        logic [31:0] ctl;
        w = 2 * (2 << sl) + 3;
        ctl = {22'h0, sl, lv, ng, fl, pl, 1'b1};
        exp_q.delete();
        gap_q.delete();
        dev.log_cmd.delete();
        dev.log_cyc.delete();
        add({LEVEL_SELECT_REG, MON1_LEVEL_FIELD, 4'h0, lv}, 0);
        if (pl) begin
            add({MON1_CTRL0_REG, MON1_RESET_SELECT | MON1_NEGATION_TYPE, 1'b1, ng, 6'h00}, 2);
            add({MON1_CTRL0_REG, MON1_INT_RESET_EN, 8'h01}, 2);
            add({COMPARATOR_CTRL_REG, MON1_CIRCUIT_EN, MON1_CIRCUIT_EN}, 2);
            add({MON1_CTRL0_REG, MON1_CMP_OUT_EN, MON1_CMP_OUT_EN}, 2 + S);
        end else begin
            add({COMPARATOR_CTRL_REG, MON1_CIRCUIT_EN, MON1_CIRCUIT_EN}, 2);
            if (fl) begin
                add({MON1_CTRL0_REG, MON1_FILTER_CLK_SEL, 2'b00, sl, 4'h0}, 2 + S);
                add({MON1_CTRL0_REG, MON1_FILTER_DISABLE, 8'h00}, 2);
            end
            add({MON1_CTRL0_REG, MON1_RESET_SELECT | MON1_NEGATION_TYPE, 1'b1, ng, 6'h00},
                fl ? 2 + w : 2 + S);
            add({MON1_STATUS_REG, MON1_DETECT_FLAG, 8'h00}, 2);
            add({MON1_CTRL0_REG, MON1_INT_RESET_EN, 8'h01}, 2);
            add({MON1_CTRL0_REG, MON1_CMP_OUT_EN, MON1_CMP_OUT_EN}, 2);
        end
        xfer(1'b1, CTRL_OFS, ctl);
        xfer(1'b1, CTRL_OFS, ctl ^ 32'h0000_00F0);
        do xfer(1'b0, STATUS_OFS, 32'h0); while (rd[STAT_BUSY_BIT] === 1'b1);
        check(rd[STAT_DONE_BIT], 1'b1, "done flag");
        xfer(1'b0, CTRL_OFS, 32'h0);
        check(rd, {22'h0, sl, lv, ng, fl & ~pl, pl, 1'b0}, "latched config");
        check(dev.log_cmd.size(), exp_q.size(), "write count");
        foreach (exp_q[i]) begin
            check(dev.log_cmd[i], exp_q[i], "device write");
            if (i > 0) check(dev.log_cyc[i] - dev.log_cyc[i - 1] >= gap_q[i], 1, "wait");
        end
    endtask
    // sticky events, masking, clearing and the unmapped place
    task automatic events();
        xfer(1'b1, IRQ_EN_OFS, 32'h0);
        xfer(1'b0, IRQ_STAT_OFS, 32'h0);
        check(rd, 32'h1, "done event");
        // irq follows registers written at the access edge: look once settled
        @(negedge pclk);
        check(irq, 1'b0, "masked irq");
        xfer(1'b1, IRQ_EN_OFS, 32'h1);
        @(negedge pclk);
        check(irq, 1'b1, "enabled irq");
        xfer(1'b1, IRQ_CLR_OFS, 32'h1);
        @(negedge pclk);
        check(irq, 1'b0, "cleared irq");
        xfer(1'b1, IRQ_EN_OFS, 32'h6);
        supply_low <= 1'b1;
        repeat (60) begin
            @(posedge pclk);
            if (irq === 1'b1) break;
        end
        xfer(1'b0, STATUS_OFS, 32'h0);
        check(rd[3:2], 2'b11, "reset and detect seen");
        xfer(1'b0, IRQ_STAT_OFS, 32'h0);
        check(rd, 32'h6, "pin events");
        supply_low <= 1'b0;
        xfer(1'b1, IRQ_CLR_OFS, 32'h6);
        @(negedge pclk);
        check(irq, 1'b0, "events cleared");
        xfer(1'b0, 8'h40, 32'h0);
        check({er, rd}, {1'b1, 32'h0}, "unmapped read");
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        run(1'b1, 1'b1, 1'b1, 4'hF, 2'h2);
        slow <= 1'b1;
        run(1'b0, 1'b0, 1'b0, 4'h0, 2'h1);
        slow <= 1'b0;
        for (int s = 3; s >= 0; s--) run(1'b0, 1'b1, s[0], 4'(5 + s), 2'(s));
        events();
        end_of_test();
    end
endmodule
